// ---- design/dbg_port_regs.svh ----
`ifndef DBG_PORT_REGS_SVH
`define DBG_PORT_REGS_SVH

// ==========================================
// link timing and framing
`define DBG_BREAK_CYCLES 16'h1000
`define DBG_BREAK_LAST 16'h0FFF
`define DBG_AB_SHIFT 3
`define DBG_START_BIT 4'h0
`define DBG_LAST_DATA_BIT 4'h8
`define DBG_STOP_BIT 4'h9
`define DBG_CNT_MAX 16'hFFFF

// ==========================================
// structure
`define DBG_BYTE_W 8
`define DBG_CNT_W 16
`define DBG_FIFO_DEPTH 4

`endif

// ---- design/dbg_port_pkg.sv ----
package dbg_port_pkg;

   // ==========================================
   // link state, one-hot
   typedef enum logic [5:0] {
      S_BAUD = 6'h01,
      S_IDLE = 6'h02,
      S_RX = 6'h04,
      S_TX = 6'h08,
      S_BREAK = 6'h10,
      S_WAIT_HIGH = 6'h20
   } link_state_t;

endpackage : dbg_port_pkg

// ---- design/byte_fifo.sv ----
`timescale 1ns/1ps

module byte_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [W-1:0] mem_q [DEPTH];
   logic [W-1:0] mem_d [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready = (cnt_q != FULL);
   // head word and its valid are registered, so out_data and out_valid come from flops
   logic [W-1:0] out_data_q;
   logic out_valid_q;

   assign out_valid = out_valid_q;
   assign out_data = out_data_q;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // ==========================================
   // storage
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_slot
         always_comb begin
            mem_d[g] = (push && wr_q == AW'(g)) ? in_data : mem_q[g];
         end
         always_ff @(posedge ref_clk) begin
            mem_q[g] <= mem_d[g];
         end
      end
   endgenerate

   // ==========================================
   // pointers
   always_comb begin
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         wr_d = (wr_q == LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = (rd_q == LAST) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         out_valid_q <= 1'b0;
         out_data_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         out_valid_q <= (cnt_d != '0);
         out_data_q <= mem_d[rd_d];
      end
   end

   property p_fifo_count;
      @(posedge ref_clk) disable iff (rst)
      (push && !pop) |=> (cnt_q == $past(cnt_q) + 1'b1);
   endproperty
   a_fifo_count: assert property (p_fifo_count) else $error("fifo count did not rise on push");

endmodule : byte_fifo

// ---- design/single_pin_debug_port.sv ----
`timescale 1ns/1ps
`include "dbg_port_regs.svh"

module single_pin_debug_port (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic debug_serial_pin_in,
   output logic debug_serial_pin_out,
   output logic debug_serial_pin_oe,
   output logic [`DBG_BYTE_W-1:0] cmd_data,
   output logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [`DBG_BYTE_W-1:0] rsp_data,
   input wire logic rsp_valid,
   output logic rsp_ready,
   output logic cmd_abort,
   input wire logic debug_enter,
   input wire logic debug_exit,
   input wire logic stop_mode,
   input wire logic halt_mode,
   input wire logic wdt_enabled,
   output logic cpu_fetch_stop,
   output logic sys_clk_run,
   output logic periph_run,
   output logic halt_exit,
   output logic wdt_refresh
);
   dbg_port_pkg::link_state_t state_q, state_d;
   logic [`DBG_CNT_W-1:0] cnt_q, cnt_d, bit_q, bit_d;
   logic [3:0] bitn_q, bitn_d;
   logic [`DBG_BYTE_W-1:0] shreg_q, shreg_d;
   logic oe_q, oe_d, rsp_ready_q, rsp_ready_d, abort_q, abort_d;
   logic push, err, fifo_in_ready, pin;
   logic was_rst_q, debug_q, debug_d;
   logic clk_run_q, periph_q, halt_exit_q, wdt_q;

   assign pin = debug_serial_pin_in;
   assign debug_serial_pin_out = 1'b0;
   assign debug_serial_pin_oe = oe_q;
   assign rsp_ready = rsp_ready_q;
   assign cmd_abort = abort_q;

   // ==========================================
   // received bytes toward the debug controller
   byte_fifo #(
      .W(`DBG_BYTE_W),
      .DEPTH(`DBG_FIFO_DEPTH)
   ) u_cmd_fifo (
      .ref_clk(ref_clk),
      .rst(rst),
      .in_data(shreg_q),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .out_data(cmd_data),
      .out_valid(cmd_valid),
      .out_ready(cmd_ready)
   );

   // ==========================================
   // link: autobaud, receiver, transmitter, break
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      bit_d = bit_q;
      bitn_d = bitn_q;
      shreg_d = shreg_q;
      oe_d = 1'b0;
      push = 1'b0;
      err = 1'b0;
      abort_d = 1'b0;
      case (state_q)
         dbg_port_pkg::S_BAUD: begin
            if (!pin) begin
               cnt_d = (cnt_q == `DBG_CNT_MAX) ? cnt_q : cnt_q + 1'b1;
            end else if (cnt_q != '0) begin
               // eight low bit times measured
               bit_d = cnt_q >> `DBG_AB_SHIFT;
               if (bit_d == '0) begin
                  bit_d = `DBG_CNT_W'(1);
               end
               cnt_d = '0;
               state_d = dbg_port_pkg::S_IDLE;
            end
         end
         dbg_port_pkg::S_IDLE: begin
            // receive waits for room, which stalls the receiver
            if (!pin && fifo_in_ready) begin
               state_d = dbg_port_pkg::S_RX;
               cnt_d = bit_q >> 1;
               bitn_d = `DBG_START_BIT;
            end else if (pin && rsp_valid && rsp_ready_q) begin
               state_d = dbg_port_pkg::S_TX;
               shreg_d = rsp_data;
               cnt_d = bit_q - 1'b1;
               bitn_d = `DBG_START_BIT;
               oe_d = 1'b1;
            end
         end
         dbg_port_pkg::S_RX: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               cnt_d = bit_q - 1'b1;
               bitn_d = bitn_q + 1'b1;
               if (bitn_q == `DBG_START_BIT) begin
                  if (pin) begin
                     state_d = dbg_port_pkg::S_IDLE;
                  end
               end else if (bitn_q <= `DBG_LAST_DATA_BIT) begin
                  shreg_d = {pin, shreg_q[`DBG_BYTE_W-1:1]};
               end else if (!pin) begin
                  err = 1'b1;
               end else begin
                  push = 1'b1;
                  state_d = dbg_port_pkg::S_IDLE;
               end
            end
         end
         dbg_port_pkg::S_TX: begin
            if (!oe_q && !pin) begin
               err = 1'b1;
            end else if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
               oe_d = oe_q;
            end else begin
               cnt_d = bit_q - 1'b1;
               bitn_d = bitn_q + 1'b1;
               if (bitn_q == `DBG_STOP_BIT) begin
                  state_d = dbg_port_pkg::S_IDLE;
               end else if (bitn_q != `DBG_LAST_DATA_BIT) begin
                  oe_d = !shreg_q[0];
                  shreg_d = shreg_q >> 1;
               end
            end
         end
         dbg_port_pkg::S_BREAK: begin
            if (cnt_q == `DBG_BREAK_LAST) begin
               state_d = dbg_port_pkg::S_WAIT_HIGH;
               cnt_d = '0;
            end else begin
               oe_d = 1'b1;
               cnt_d = cnt_q + 1'b1;
            end
         end
         dbg_port_pkg::S_WAIT_HIGH: begin
            if (pin) begin
               state_d = dbg_port_pkg::S_BAUD;
               cnt_d = '0;
            end
         end
         default: begin
            state_d = dbg_port_pkg::S_WAIT_HIGH;
            cnt_d = '0;
         end
      endcase
      if (err) begin
         state_d = dbg_port_pkg::S_BREAK;
         cnt_d = '0;
         oe_d = 1'b1;
         abort_d = 1'b1;
      end
      rsp_ready_d = (state_d == dbg_port_pkg::S_IDLE);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= dbg_port_pkg::S_WAIT_HIGH;
         cnt_q <= '0;
         bit_q <= `DBG_CNT_W'(1);
         bitn_q <= '0;
         shreg_q <= '0;
         oe_q <= 1'b0;
         rsp_ready_q <= 1'b0;
         abort_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         bit_q <= bit_d;
         bitn_q <= bitn_d;
         shreg_q <= shreg_d;
         oe_q <= oe_d;
         rsp_ready_q <= rsp_ready_d;
         abort_q <= abort_d;
      end
   end

   // ==========================================
   // debug controller
   always_comb begin
      debug_d = debug_q;
      if (was_rst_q && !pin) begin
         debug_d = 1'b1;
      end else if (debug_enter) begin
         debug_d = 1'b1;
      end else if (debug_exit) begin
         debug_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         was_rst_q <= 1'b1;
         debug_q <= 1'b0;
         clk_run_q <= 1'b1;
         periph_q <= 1'b1;
         halt_exit_q <= 1'b0;
         wdt_q <= 1'b0;
      end else begin
         was_rst_q <= 1'b0;
         debug_q <= debug_d;
         clk_run_q <= !stop_mode;
         periph_q <= !stop_mode;
         halt_exit_q <= debug_d && halt_mode;
         wdt_q <= debug_d && wdt_enabled;
      end
   end

   assign cpu_fetch_stop = debug_q;
   assign sys_clk_run = clk_run_q;
   assign periph_run = periph_q;
   assign halt_exit = halt_exit_q;
   assign wdt_refresh = wdt_q;

   // ==========================================
   // checks
   property p_idle_released;
      @(posedge ref_clk) disable iff (rst)
      (state_q == dbg_port_pkg::S_IDLE || state_q == dbg_port_pkg::S_BAUD) |-> !oe_q;
   endproperty
   a_idle_released: assert property (p_idle_released) else $error("line driven while idle");

   property p_no_rx_in_tx;
      @(posedge ref_clk) disable iff (rst)
      (state_q == dbg_port_pkg::S_TX) |-> !push;
   endproperty
   a_no_rx_in_tx: assert property (p_no_rx_in_tx) else $error("byte received while sending");

   property p_start_bit;
      @(posedge ref_clk) disable iff (rst)
      (state_q == dbg_port_pkg::S_IDLE && pin && rsp_valid && rsp_ready_q)
         |=> oe_q && state_q == dbg_port_pkg::S_TX && bitn_q == `DBG_START_BIT;
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("start bit not driven low");

   property p_strap;
      @(posedge ref_clk) disable iff (rst)
      (was_rst_q && !pin) |=> cpu_fetch_stop;
   endproperty
   a_strap: assert property (p_strap) else $error("strap low did not enter debug");

   property p_wdt;
      @(posedge ref_clk) disable iff (rst)
      $past(was_rst_q) == 1'b0 |-> wdt_refresh == (cpu_fetch_stop && $past(wdt_enabled));
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog refresh wrong");

   property p_halt;
      @(posedge ref_clk) disable iff (rst)
      (debug_q && halt_mode && !debug_exit) |=> halt_exit;
   endproperty
   a_halt: assert property (p_halt) else $error("halt not left in debug");

   property p_clk_run;
      @(posedge ref_clk) disable iff (rst)
      !stop_mode |=> sys_clk_run;
   endproperty
   a_clk_run: assert property (p_clk_run) else $error("clock stopped outside deep stop");

   property p_periph;
      @(posedge ref_clk) disable iff (rst)
      stop_mode |=> !periph_run;
   endproperty
   a_periph: assert property (p_periph) else $error("peripherals run in deep stop");

   property p_frame_err;
      @(posedge ref_clk) disable iff (rst)
      (state_q == dbg_port_pkg::S_RX && cnt_q == '0 && bitn_q == `DBG_STOP_BIT && !pin)
         |=> oe_q && cmd_abort ##1 oe_q [*8];
   endproperty
   a_frame_err: assert property (p_frame_err) else $error("framing error gave no break");

endmodule : single_pin_debug_port

// ---- tb/debug_host_model.sv ----
`timescale 1ns/1ps

// ==========================================
// host behind serial adapter, pulls low only
module debug_host_model #(
   parameter int BIT = 16
) (
   input wire logic ref_clk,
   input wire logic line,
   output logic host_oe
);
   initial host_oe = 1'b0;

   task automatic hold(input logic v);
      @(posedge ref_clk);
      host_oe <= v;
   endtask : hold

   task automatic send(input logic [7:0] b, input logic stop_hi);
      int i;
      hold(1'b1);
      repeat (BIT - 1) @(posedge ref_clk);
      for (i = 0; i < 8; i++) begin
         hold(~b[i]);
         repeat (BIT - 1) @(posedge ref_clk);
      end
      hold(~stop_hi);
      repeat (BIT - 1) @(posedge ref_clk);
      hold(1'b0);
      repeat (BIT) @(posedge ref_clk);
   endtask : send

   // listen only while the device talks
   task automatic recv(output logic [7:0] b, output logic ok);
      int n;
      int i;
      ok = 1'b0;
      b = 8'h00;
      for (n = 0; n < 400 && line; n++) @(posedge ref_clk);
      if (!line) begin
         repeat (BIT / 2) @(posedge ref_clk);
         for (i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge ref_clk);
            b[i] = line;
         end
         repeat (BIT) @(posedge ref_clk);
         ok = line;
      end
   endtask : recv
endmodule : debug_host_model

// ---- tb/single_pin_debug_port_tb_top.sv ----
`timescale 1ns/1ps

module single_pin_debug_port_tb_top;
   localparam int BIT = 16;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_ready = 1'b0;
   logic rsp_valid = 1'b0;
   logic debug_enter = 1'b0;
   logic debug_exit = 1'b0;
   logic stop_mode = 1'b0;
   logic halt_mode = 1'b0;
   logic wdt_enabled = 1'b0;
   logic [7:0] rsp_data = 8'h00;
   logic pin_out, pin_oe, host_oe, line, cmd_valid, rsp_ready, cmd_abort;
   logic fetch_stop, clk_run, per_run, halt_exit, wdt_refresh, ok;
   logic abort_seen = 1'b0;
   logic [7:0] cmd_data, got, v;
   logic [7:0] q[$];
   int err_count = 0;
   int samples_checked = 0;
   int seed = 50;
   int i, n;

   assign line = ~(pin_oe | host_oe);
   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (cmd_abort === 1'b1) abort_seen <= 1'b1;

   single_pin_debug_port dut (.ref_clk(ref_clk), .rst(rst), .debug_serial_pin_in(line),
      .debug_serial_pin_out(pin_out), .debug_serial_pin_oe(pin_oe), .cmd_data(cmd_data),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_data(rsp_data),
      .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .cmd_abort(cmd_abort),
      .debug_enter(debug_enter), .debug_exit(debug_exit), .stop_mode(stop_mode),
      .halt_mode(halt_mode), .wdt_enabled(wdt_enabled), .cpu_fetch_stop(fetch_stop),
      .sys_clk_run(clk_run), .periph_run(per_run), .halt_exit(halt_exit),
      .wdt_refresh(wdt_refresh));

   debug_host_model #(.BIT(BIT)) host (.ref_clk(ref_clk), .line(line), .host_oe(host_oe));

   // ==========================================
   // checking and verdict
   function automatic logic [7:0] ctrl_exp(input logic d, h, w, s);
      return {3'h0, d, ~s, ~s, d & h, d & w};
   endfunction : ctrl_exp

   task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v);
      samples_checked++;
      if (got_v !== exp_v) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got_v, exp_v);
      end
   endtask : chk

   task automatic settle();
      @(posedge ref_clk);
      #1;
   endtask : settle

   task automatic complete_run();
      $display("checks=%0d errors=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   initial begin
      #200000;
      err_count++;
      complete_run();
   end

   // ==========================================
   // scenarios
   initial begin
      repeat (4) @(posedge ref_clk);
      #1;
      chk({pin_out, pin_oe, rsp_ready, cmd_valid, cmd_abort}, 16'h0000);
      chk({3'h0, fetch_stop, clk_run, per_run, halt_exit, wdt_refresh},
         ctrl_exp(1'b0, 1'b0, 1'b0, 1'b0));
      @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      host.send(8'h80, 1'b1);
      settle();
      chk({rsp_ready, cmd_valid}, 16'h0002);
      for (i = 0; i < 4; i++) begin
         v = $random(seed);
         q.push_back(v);
         host.send(v, 1'b1);
      end
      settle();
      chk(cmd_valid, 16'h0001);
      for (i = 0; i < 4; i++) begin
         chk(cmd_data, q[i]);
         @(posedge ref_clk);
         cmd_ready <= 1'b1;
         @(posedge ref_clk);
         cmd_ready <= 1'b0;
         #1;
      end
      chk(cmd_valid, 16'h0000);
      for (i = 0; i < 3; i++) begin
         for (n = 0; n < 400 && rsp_ready !== 1'b1; n++) settle();
         @(posedge ref_clk);
         v = $random(seed);
         rsp_valid <= 1'b1;
         rsp_data <= v;
         @(posedge ref_clk);
         rsp_valid <= 1'b0;
         host.recv(got, ok);
         chk(got, v);
         chk({ok, pin_out}, 16'h0002);
      end
      for (i = 0; i < 6; i++) begin
         @(posedge ref_clk);
         v = $random(seed);
         {halt_mode, wdt_enabled, stop_mode} <= v[2:0];
         debug_enter <= 1'b1;
         @(posedge ref_clk);
         debug_enter <= 1'b0;
         repeat (2) settle();
         chk({3'h0, fetch_stop, clk_run, per_run, halt_exit, wdt_refresh},
            ctrl_exp(1'b1, halt_mode, wdt_enabled, stop_mode));
         @(posedge ref_clk);
         debug_exit <= 1'b1;
         @(posedge ref_clk);
         debug_exit <= 1'b0;
         repeat (2) settle();
         chk({3'h0, fetch_stop, clk_run, per_run, halt_exit, wdt_refresh},
            ctrl_exp(1'b0, halt_mode, wdt_enabled, stop_mode));
      end
      @(posedge ref_clk);
      {halt_mode, wdt_enabled, stop_mode} <= 3'h0;
      rst <= 1'b1;
      host.hold(1'b1);
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) settle();
      chk(fetch_stop, 16'h0001);
      host.hold(1'b0);
      repeat (BIT) @(posedge ref_clk);
      host.send(8'h80, 1'b1);
      fork
         host.send(8'h5A, 1'b0);
         begin
            for (n = 0; n < 400 && pin_oe !== 1'b1; n++) settle();
            for (n = 0; n < 5000 && pin_oe === 1'b1; n++) settle();
         end
      join
      chk({abort_seen, 15'h0000}, 16'h8000);
      chk(n, 16'h1000);
      repeat (BIT) @(posedge ref_clk);
      host.send(8'h80, 1'b1);
      settle();
      chk(rsp_ready, 16'h0001);
      complete_run();
   end
endmodule : single_pin_debug_port_tb_top
